// ---- common/sdt_defines.svh ----
// Notes on behaviour
// - override clear: chip logic picks subrange code
// - override set: stored 6-bit code drives ADC
// - stored code ignored while override is clear
// - exposures 1-6 consecutive; bit7 override, bits5:0
// - writing start bit launches exactly one measurement
// - start bit self-clears when measurement finishes
// - integer result read-only two's complement degrees
// - fraction result read-only 4 bits, sixteenths
`ifndef SDT_DEFINES_SVH
`define SDT_DEFINES_SVH

`define SDT_ADDR_EXP1_DAC 8'h2C
`define SDT_ADDR_EXP2_DAC 8'h2D
`define SDT_ADDR_EXP3_DAC 8'h2E
`define SDT_ADDR_EXP4_DAC 8'h2F
`define SDT_ADDR_EXP5_DAC 8'h30
`define SDT_ADDR_EXP6_DAC 8'h31
`define SDT_ADDR_TEMP_CFG 8'h40
`define SDT_ADDR_TEMP_INT 8'h41
`define SDT_ADDR_TEMP_FRACTION_RESULT 8'h42

`define SDT_EXP_COUNT 6
`define SDT_OVR_BIT 7
`define SDT_CODE_MSB 5
`define SDT_CODE_LSB 0
`define SDT_TEMP_START_BIT 0
`define SDT_FRAC_MSB 3

`define SDT_RST_CODE 6'h00
`define SDT_RST_OVR 1'b0
`define SDT_RST_INT 8'h00
`define SDT_RST_FRAC 4'h0
`define SDT_RST_BYTE 8'h00

`endif

// ---- common/sdt_pkg.sv ----
package sdt_pkg;

    typedef logic [5:0] sdt_code_t;
    typedef logic [2:0] sdt_exp_idx_t;

    typedef enum logic [1:0] {
        SDT_IDLE = 2'b00,
        SDT_CONV = 2'b01,
        SDT_DONE = 2'b10
    } sdt_temp_state_t;

endpackage

// ---- core/sdt_regs.sv ----
`timescale 1ns/10ps
`include "sdt_defines.svh"

module sdt_regs
    import sdt_pkg::*;
#(
    parameter int EXP_COUNT = `SDT_EXP_COUNT
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [2:0] exp_index,
    input wire logic [5:0] auto_subrange_code,
    output logic [5:0] subrange_code,
    output logic subrange_override,
    output logic temp_conv_start,
    input wire logic temp_conv_done,
    input wire logic [7:0] temp_int_in,
    input wire logic [3:0] temp_fraction_result_in
);

    // slot 0..5 for exposures 1..6, EXP_COUNT when not an exposure
    function automatic logic [2:0] exp_slot(input logic [7:0] addr);
        logic [7:0] rel;
        rel = addr - `SDT_ADDR_EXP1_DAC;
        if (addr >= `SDT_ADDR_EXP1_DAC && rel < 8'(EXP_COUNT)) begin
            exp_slot = rel[2:0];
        end else begin
            exp_slot = 3'(EXP_COUNT);
        end
    endfunction

    logic ovr_reg [EXP_COUNT];
    logic ovr_next [EXP_COUNT];
    sdt_code_t code_reg [EXP_COUNT];
    sdt_code_t code_next [EXP_COUNT];
    logic [2:0] wr_slot;
    logic [2:0] rd_slot;

    assign wr_slot = exp_slot(reg_addr);
    assign rd_slot = exp_slot(reg_addr);

    genvar g;
    generate
        for (g = 0; g < EXP_COUNT; g++) begin : g_exp
            always_comb begin
                ovr_next[g] = ovr_reg[g];
                code_next[g] = code_reg[g];
                if (reg_wr && wr_slot == 3'(g)) begin
                    ovr_next[g] = reg_wdata[`SDT_OVR_BIT];
                    // bit 6 is reserved and never stored
                    code_next[g] =
                        reg_wdata[`SDT_CODE_MSB:`SDT_CODE_LSB];
                end
            end

            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    ovr_reg[g] <= `SDT_RST_OVR;
                    code_reg[g] <= `SDT_RST_CODE;
                end else begin
                    ovr_reg[g] <= ovr_next[g];
                    code_reg[g] <= code_next[g];
                end
            end
        end
    endgenerate

    // code applied to the readout ADC in the current exposure
    logic [5:0] dac_code_reg, dac_code_next;
    logic dac_ovr_reg, dac_ovr_next;
    logic exp_valid;

    assign exp_valid = (exp_index < 3'(EXP_COUNT));

    always_comb begin
        dac_code_next = auto_subrange_code;
        dac_ovr_next = 1'b0;
        if (exp_valid && ovr_reg[exp_index]) begin
            dac_code_next = code_reg[exp_index];
            dac_ovr_next = 1'b1;
        end
        // stored code is not even looked at without override
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dac_code_reg <= `SDT_RST_CODE;
            dac_ovr_reg <= 1'b0;
        end else begin
            dac_code_reg <= dac_code_next;
            dac_ovr_reg <= dac_ovr_next;
        end
    end

    assign subrange_code = dac_code_reg;
    assign subrange_override = dac_ovr_reg;

    // temperature measurement
    logic temp_start_req;
    logic temp_busy;
    logic [7:0] temp_int;
    logic [3:0] temp_fraction_result;

    assign temp_start_req = reg_wr && reg_addr == `SDT_ADDR_TEMP_CFG &&
        reg_wdata[`SDT_TEMP_START_BIT];

    sdt_temp_seq u_temp (
        .clk(clk),
        .rst(rst),
        .start_req(temp_start_req),
        .conv_done(temp_conv_done),
        .int_in(temp_int_in),
        .frac_in(temp_fraction_result_in),
        .conv_start(temp_conv_start),
        .busy(temp_busy),
        .int_result(temp_int),
        .frac_result(temp_fraction_result)
    );

    // read port, one cycle latency
    logic [7:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;

    always_comb begin
        rdata_next = rdata_reg;
        rvalid_next = reg_rd;
        if (reg_rd) begin
            rdata_next = `SDT_RST_BYTE;
            if (rd_slot < 3'(EXP_COUNT)) begin
                rdata_next[`SDT_OVR_BIT] = ovr_reg[rd_slot];
                rdata_next[`SDT_CODE_MSB:`SDT_CODE_LSB] =
                    code_reg[rd_slot];
            end else begin
                unique case (reg_addr)
                    `SDT_ADDR_TEMP_CFG:
                        rdata_next[`SDT_TEMP_START_BIT] = temp_busy;
                    `SDT_ADDR_TEMP_INT:
                        rdata_next = temp_int;
                    `SDT_ADDR_TEMP_FRACTION_RESULT:
                        rdata_next[`SDT_FRAC_MSB:0] = temp_fraction_result;
                    default:
                        rdata_next = `SDT_RST_BYTE;
                endcase
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= `SDT_RST_BYTE;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign reg_rvalid = rvalid_reg;

    // checks
    sequence s_exp_read;
        reg_rd && rd_slot < 3'(EXP_COUNT);
    endsequence

    sequence s_ovr_active;
        exp_valid && ovr_reg[exp_index];
    endsequence

    ovr_select_a : assert property (
        @(posedge clk) disable iff (rst)
        s_ovr_active |=> subrange_override &&
            subrange_code == $past(code_reg[exp_index]))
        else $error("override code not applied");

    auto_select_a : assert property (
        @(posedge clk) disable iff (rst)
        !exp_valid || !ovr_reg[exp_index] |=> !subrange_override &&
            subrange_code == $past(auto_subrange_code))
        else $error("chip code not applied without override");

    code_ignored_a : assert property (
        @(posedge clk) disable iff (rst)
        exp_valid && !ovr_reg[exp_index] && $stable(auto_subrange_code)
            ##1 exp_valid && !ovr_reg[exp_index]
            && $stable(auto_subrange_code) && $stable(exp_index)
            |=> $stable(subrange_code))
        else $error("stored code leaked while override clear");

    reserved_zero_a : assert property (
        @(posedge clk) disable iff (rst)
        s_exp_read |=> reg_rvalid && !reg_rdata[6])
        else $error("reserved bit read non-zero");

    exp_write_read_a : assert property (
        @(posedge clk) disable iff (rst)
        // the host leaves one idle cycle between strobes
        reg_wr && reg_addr == `SDT_ADDR_EXP4_DAC && !reg_rd
            ##1 !reg_wr
            ##1 reg_rd && reg_addr == `SDT_ADDR_EXP4_DAC && !reg_wr
            |=> reg_rdata == {$past(reg_wdata, 3) & 8'hBF})
        else $error("exposure register readback wrong");

    start_clear_a : assert property (
        @(posedge clk) disable iff (rst)
        temp_busy && temp_conv_done && !temp_start_req
            ##1 !temp_start_req |=> !temp_busy)
        else $error("start bit did not clear after finish");

    temp_read_a : assert property (
        @(posedge clk) disable iff (rst)
        reg_rd && reg_addr == `SDT_ADDR_TEMP_INT
            |=> reg_rdata == $past(temp_int))
        else $error("integer result read wrong");

    frac_read_a : assert property (
        @(posedge clk) disable iff (rst)
        reg_rd && reg_addr == `SDT_ADDR_TEMP_FRACTION_RESULT
            |=> reg_rdata == {4'h0, $past(temp_fraction_result)})
        else $error("fraction result read wrong");

endmodule

// ---- core/sdt_temp_seq.sv ----
`timescale 1ns/10ps
`include "sdt_defines.svh"

module sdt_temp_seq
    import sdt_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic start_req,
    input wire logic conv_done,
    input wire logic [7:0] int_in,
    input wire logic [3:0] frac_in,
    output logic conv_start,
    output logic busy,
    output logic [7:0] int_result,
    output logic [3:0] frac_result
);

    sdt_temp_state_t state_reg, state_next;
    logic start_reg, start_next;
    logic [7:0] int_reg, int_next;
    logic [3:0] frac_reg, frac_next;

    always_comb begin
        state_next = state_reg;
        start_next = 1'b0;
        int_next = int_reg;
        frac_next = frac_reg;
        unique case (state_reg)
            SDT_IDLE: begin
                if (start_req) begin
                    state_next = SDT_CONV;
                    start_next = 1'b1;
                end
            end
            SDT_CONV: begin
                // a repeated start while converting adds nothing
                if (conv_done) begin
                    int_next = int_in;
                    frac_next = frac_in;
                    state_next = SDT_DONE;
                end
            end
            SDT_DONE: begin
                // a start landing on the clearing cycle wins
                if (start_req) begin
                    state_next = SDT_CONV;
                    start_next = 1'b1;
                end else begin
                    state_next = SDT_IDLE;
                end
            end
            default: state_next = SDT_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= SDT_IDLE;
            start_reg <= 1'b0;
            int_reg <= `SDT_RST_INT;
            frac_reg <= `SDT_RST_FRAC;
        end else begin
            state_reg <= state_next;
            start_reg <= start_next;
            int_reg <= int_next;
            frac_reg <= frac_next;
        end
    end

    assign conv_start = start_reg;
    assign busy = (state_reg != SDT_IDLE);
    assign int_result = int_reg;
    assign frac_result = frac_reg;

    sequence s_done_seen;
        (state_reg == SDT_CONV) && conv_done;
    endsequence

    sequence s_result_then_clear;
        (int_reg == $past(int_in)) && busy ##1 !busy || start_reg;
    endsequence

    result_order_a : assert property (
        @(posedge clk) disable iff (rst)
        s_done_seen |=> s_result_then_clear)
        else $error("result not loaded before start bit cleared");

    one_launch_a : assert property (
        @(posedge clk) disable iff (rst)
        conv_start |=> !conv_start)
        else $error("conversion start held longer than one cycle");

    launch_cause_a : assert property (
        @(posedge clk) disable iff (rst)
        $rose(busy) |-> conv_start)
        else $error("busy rose without a conversion start");

    hold_result_a : assert property (
        @(posedge clk) disable iff (rst)
        !$past(conv_done) |-> $stable(int_reg) && $stable(frac_reg))
        else $error("result changed without a finished conversion");

endmodule

// ---- verif/sdt_conv_model.sv ----
`timescale 1ns/10ps

// stands in for the temperature converter behind the register bank
module sdt_conv_model #(
    parameter int LAT = 20
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic conv_start,
    input wire logic stray,
    input wire logic [7:0] int_val,
    input wire logic [3:0] frac_val,
    output logic done,
    output logic [7:0] int_out,
    output logic [3:0] frac_out
);
    logic [7:0] cnt;

    // result lines only hold in the done cycle, so a late capture shows up
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 8'h00;
            done <= 1'b0;
            int_out <= 8'h00;
            frac_out <= 4'h0;
        end else begin
            done <= 1'b0;
            int_out <= ~int_out;
            frac_out <= ~frac_out;
            if (conv_start) begin
                cnt <= 8'(LAT);
            end else if (cnt != 8'h00) begin
                cnt <= cnt - 8'h01;
            end
            // stray pulses test that idle completions are dropped
            if (cnt == 8'h01 || stray) begin
                done <= 1'b1;
                int_out <= int_val;
                frac_out <= frac_val;
            end
        end
    end
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/10ps
`include "sdt_defines.svh"

module tb;
    import sdt_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, int_v;
    logic reg_wr = 1'b0, reg_rd = 1'b0, reg_rvalid, stray = 1'b0;
    logic [2:0] exp_index = 3'h6;
    logic [5:0] auto_code = 6'h00, subrange_code;
    logic subrange_override, conv_start, conv_done;
    logic [7:0] conv_int;
    logic [3:0] conv_frac, frac_v;
    logic [7:0] v, v2;
    int failures = 0, comparisons = 0, starts = 0, cycles = 0, s0;

    sdt_regs i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .exp_index(exp_index), .auto_subrange_code(auto_code),
        .subrange_code(subrange_code),
        .subrange_override(subrange_override),
        .temp_conv_start(conv_start), .temp_conv_done(conv_done),
        .temp_int_in(conv_int), .temp_fraction_result_in(conv_frac));

    sdt_conv_model #(.LAT(20)) i_conv (.clk(clk), .rst(rst),
        .conv_start(conv_start), .stray(stray), .int_val(int_v),
        .frac_val(frac_v), .done(conv_done), .int_out(conv_int),
        .frac_out(conv_frac));

    initial begin
        forever #5 clk = ~clk;
    end

    // a hang at any poll still ends in the verdict
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (conv_start === 1'b1) begin
            starts <= starts + 1;
        end
        if (cycles == 8000) begin
            failures = failures + 1;
            complete_run();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk);
        #1 reg_wr = 1'b0;
    endtask

    // rvalid comes exactly one cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1 reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clk);
        #1 reg_rd = 1'b0;
        d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
    endtask

    // burst: strobe held high while the address steps to the next byte
    task automatic rd_pair(input logic [7:0] a, output logic [7:0] d0,
        output logic [7:0] d1);
        @(posedge clk);
        #1 reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clk);
        #1 reg_addr = a + 8'h01;
        d0 = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
        @(posedge clk);
        #1 reg_rd = 1'b0;
        d1 = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
    endtask

    task automatic exp_path(input int i, input logic [5:0] code,
        input logic ovr);
        @(posedge clk);
        #1 exp_index = 3'(i);
        auto_code = 6'h2A ^ 6'(i);
        @(posedge clk);
        #1 check({2'h0, subrange_code}, {2'h0, code});
        check({7'h00, subrange_override}, {7'h00, ovr});
    endtask

    task automatic measure(input logic [7:0] ti, input logic [3:0] tf);
        int_v = ti;
        frac_v = tf;
        s0 = starts;
        wr(`SDT_ADDR_TEMP_CFG, 8'hFF);
        rd(`SDT_ADDR_TEMP_CFG, v);
        check(v, 8'h01);
        wr(`SDT_ADDR_TEMP_CFG, 8'h01);
        wr(`SDT_ADDR_TEMP_INT, 8'h5A);
        v = 8'h01;
        for (int k = 0; k < 40 && v[0] !== 1'b0; k++) begin
            rd(`SDT_ADDR_TEMP_CFG, v);
        end
        check(v, 8'h00);
        rd_pair(`SDT_ADDR_TEMP_INT, v, v2);
        check(v, ti);
        check(v2, {4'h0, tf});
        check(8'(starts - s0), 8'h01);
    endtask

    task automatic complete_run();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        int_v = 8'h00;
        frac_v = 4'h0;
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        for (int a = 8'h2B; a <= 8'h43; a++) begin
            rd(8'(a), v);
            check(v, 8'h00);
        end
        wr(8'h43, 8'hFF);
        rd(8'h43, v);
        check(v, 8'h00);
        for (int i = 0; i < 6; i++) begin
            wr(8'(`SDT_ADDR_EXP1_DAC + i), 8'hC0 | 8'(8'h11 + i));
            rd(8'(`SDT_ADDR_EXP1_DAC + i), v);
            check(v, 8'h80 | 8'(8'h11 + i));
            exp_path(i, 6'(6'h11 + i), 1'b1);
        end
        for (int i = 0; i < 6; i++) begin
            wr(8'(`SDT_ADDR_EXP1_DAC + i), 8'h3F);
            exp_path(i, 6'h2A ^ 6'(i), 1'b0);
        end
        wr(`SDT_ADDR_EXP2_DAC, 8'h95);
        exp_path(6, 6'h2A ^ 6'h6, 1'b0);
        measure(8'h7F, 4'hF);
        measure(8'h80, 4'h1);
        measure(8'h00, 4'h0);
        int_v = 8'h33;
        frac_v = 4'h5;
        @(posedge clk);
        #1 stray = 1'b1;
        @(posedge clk);
        #1 stray = 1'b0;
        rd(`SDT_ADDR_TEMP_INT, v);
        check(v, 8'h00);
        complete_run();
    end
endmodule
